//--- design/rwc_pkg.sv
package rwc_pkg;

    // Role byte carried by the vendor role command
    typedef enum logic [7:0] {
        ROLE_REDUNDANT = 8'h00,
        ROLE_ALWAYS_ON = 8'h01,
        ROLE_STANDBY_1 = 8'h02,
        ROLE_STANDBY_2 = 8'h03,
        ROLE_STANDBY_3 = 8'h04,
        ROLE_ALWAYS_SB = 8'h05
    } rwc_role_t;

    typedef enum logic [1:0] {
        ST_RUN_FIXED = 2'b00,
        ST_STANDBY = 2'b01,
        ST_LOAD_RUN = 2'b10,
        ST_WAKE_RUN = 2'b11
    } rwc_state_t;

    localparam logic [7:0] CMD_ROLE_CFG = 8'hd0;
    localparam rwc_role_t ROLE_RESET = ROLE_REDUNDANT;

    // Packet error check: CRC-8, x^8 + x^2 + x + 1, zero seed
    localparam logic [7:0] PEC_POLY = 8'h07;
    localparam logic [7:0] PEC_SEED = 8'h00;
    localparam logic WR_BIT = 1'b0;
    localparam logic RD_BIT = 1'b1;

    // Load-share scale and example thresholds, millivolts
    localparam int LS_FULL_MV = 8000;
    localparam int EN1_MV = 3200;
    localparam int EN2_MV = 5000;
    localparam int EN3_MV = 6700;
    localparam int DIS1_MV = 1440;
    localparam int DIS2_MV = 3010;
    localparam int DIS3_MV = 4520;

    // Wake response budget
    localparam int CLK_PERIOD_NS = 10;
    localparam int WAKE_LATENCY_NS = 100000;
    localparam int WAKE_LIMIT_CYC = WAKE_LATENCY_NS / CLK_PERIOD_NS;

    localparam int SYNC_STAGES = 2;

endpackage

//--- design/rwc_sync.sv
`timescale 1ns/100ps
`default_nettype none

module rwc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // First stage feeds only the second stage
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    meta_reg[g] <= INIT[g];
                    sync_reg[g] <= INIT[g];
                end else begin
                    meta_reg[g] <= async_i[g];
                    sync_reg[g] <= meta_reg[g];
                end
            end
        end
    endgenerate

    assign sync_o = sync_reg;

endmodule

`default_nettype wire

//--- design/rwc_wake_ctrl.sv
// Operation
// [R1] Pull wake line low on fault or undervoltage
// [R2] Wake line low turns standby units on
// [R3] Standby converter on within 100 us
// [R4] No high on wake line: everyone runs
// [R5] Standby only with an active peer present
// [R6] Standby only while line high, load low
// [R7] Standby units watch load share per position
// [R8] Enable thresholds 3.2, 5.0, 6.7 V
// [R9] Disable thresholds 1.44, 3.01, 4.52 V
// [R10] Load share full scale is 8.0 V
// [R11] Role 00h default: tri-state, low on fault
// [R12] Role 01h: runs, drives line high
// [R13] Roles 00h/01h ignore enable, always run
// [R14] Roles 02h-04h: standby positions one to three
// [R15] Role 05h: always standby configuration
// [R16] Wake line fall reverts standby roles to 00h
// [R17] Host rewrites role after a wake event
// [R18] Role via D0h byte command with PEC
// [R19] Synchronise wake line and compare results
`timescale 1ns/100ps
`default_nettype none

module rwc_wake_ctrl #(
    parameter int LS_W = 8,
    parameter int EN1_MV = rwc_pkg::EN1_MV,
    parameter int EN2_MV = rwc_pkg::EN2_MV,
    parameter int EN3_MV = rwc_pkg::EN3_MV,
    parameter int DIS1_MV = rwc_pkg::DIS1_MV,
    parameter int DIS2_MV = rwc_pkg::DIS2_MV,
    parameter int DIS3_MV = rwc_pkg::DIS3_MV,
    parameter int WAKE_LIMIT_CYC = rwc_pkg::WAKE_LIMIT_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Shared open-drain wake line
    input wire logic wake_line_i,
    output logic wake_line_o,
    output logic wake_line_oe_n_o,
    // Unit health
    input wire logic fault_i,
    input wire logic vout_low_i,
    // Digitised load-share level
    input wire logic [LS_W-1:0] load_share_i,
    // Command port from the management bus engine
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [6:0] dev_addr_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [7:0] cmd_wdata_i,
    input wire logic [7:0] cmd_pec_i,
    output logic cmd_ack_o,
    output logic cmd_err_o,
    output logic [7:0] rsp_data_o,
    output logic [7:0] rsp_pec_o,
    // Converter control and status
    output logic converter_enable_n_o,
    output logic [7:0] role_o
);

    // Load-share code for a level in millivolts, rounded down
    function automatic logic [LS_W-1:0] mv_code(input int mv);
        longint full;
        full = (longint'(1) << LS_W) - 1;
        mv_code = LS_W'((longint'(mv) * full) / rwc_pkg::LS_FULL_MV); // [R10]
    endfunction

    localparam logic [LS_W-1:0] EN1_CODE = mv_code(EN1_MV); // [R8]
    localparam logic [LS_W-1:0] EN2_CODE = mv_code(EN2_MV);
    localparam logic [LS_W-1:0] EN3_CODE = mv_code(EN3_MV);
    localparam logic [LS_W-1:0] DIS1_CODE = mv_code(DIS1_MV); // [R9]
    localparam logic [LS_W-1:0] DIS2_CODE = mv_code(DIS2_MV);
    localparam logic [LS_W-1:0] DIS3_CODE = mv_code(DIS3_MV);

    function automatic logic [LS_W-1:0] en_thr(input logic [7:0] role);
        case (role)
            rwc_pkg::ROLE_STANDBY_2: en_thr = EN2_CODE;
            rwc_pkg::ROLE_STANDBY_3: en_thr = EN3_CODE;
            default: en_thr = EN1_CODE;
        endcase
    endfunction

    function automatic logic [LS_W-1:0] dis_thr(input logic [7:0] role);
        case (role)
            rwc_pkg::ROLE_STANDBY_2: dis_thr = DIS2_CODE;
            rwc_pkg::ROLE_STANDBY_3: dis_thr = DIS3_CODE;
            default: dis_thr = DIS1_CODE;
        endcase
    endfunction

    function automatic logic is_sb_role(input logic [7:0] role);
        is_sb_role = (role >= rwc_pkg::ROLE_STANDBY_1) && (role <= rwc_pkg::ROLE_ALWAYS_SB);
    endfunction

    function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ rwc_pkg::PEC_POLY) : (c << 1);
        end
        crc8 = c;
    endfunction

    logic [7:0] role_reg;
    rwc_pkg::rwc_state_t state_reg;
    rwc_pkg::rwc_state_t state_next;
    logic load_hi_reg;
    logic wake_d_reg;
    logic wake_out_reg;
    logic wake_oe_n_reg;
    logic ack_reg;
    logic err_reg;
    logic [7:0] rsp_data_reg;
    logic [7:0] rsp_pec_reg;

    // Comparisons settle before crossing; the ADC code may change any cycle
    logic [3:0] async_in;
    logic [3:0] sync_out;
    logic wake_s;
    logic vout_low_s;
    logic above_en_s;
    logic below_dis_s;

    assign async_in = {load_share_i < dis_thr(role_reg),
                       load_share_i >= en_thr(role_reg),
                       vout_low_i,
                       wake_line_i};

    rwc_sync #(
        .WIDTH(4),
        .INIT(4'h0)
    ) u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .async_i(async_in),
        .sync_o(sync_out)
    ); // [R19]

    assign wake_s = sync_out[0];
    assign vout_low_s = sync_out[1];
    assign above_en_s = sync_out[2];
    assign below_dis_s = sync_out[3];

    logic wake_fall;
    logic pull_low;
    assign wake_fall = wake_d_reg && !wake_s;
    assign pull_low = fault_i || vout_low_s;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wake_d_reg <= 1'b0;
        end else begin
            wake_d_reg <= wake_s;
        end
    end

    // Command decode and packet check
    logic [7:0] pec_wr;
    logic [7:0] pec_rd;
    logic ours;
    logic pec_ok;
    logic val_ok;
    logic write_take;

    assign pec_wr = crc8(crc8(crc8(rwc_pkg::PEC_SEED, {dev_addr_i, rwc_pkg::WR_BIT}),
                              cmd_code_i), cmd_wdata_i);
    assign pec_rd = crc8(crc8(crc8(crc8(rwc_pkg::PEC_SEED, {dev_addr_i, rwc_pkg::WR_BIT}),
                                   cmd_code_i), {dev_addr_i, rwc_pkg::RD_BIT}), role_reg);
    assign ours = cmd_valid_i && (cmd_code_i == rwc_pkg::CMD_ROLE_CFG);
    assign pec_ok = (cmd_pec_i == pec_wr);
    assign val_ok = cmd_wdata_i <= rwc_pkg::ROLE_ALWAYS_SB;
    assign write_take = ours && cmd_write_i && pec_ok && val_ok; // [R18]

    // Role register; a wake fall in a standby role beats a host write in the same cycle
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            role_reg <= rwc_pkg::ROLE_RESET; // [R11]
        end else if (wake_fall && is_sb_role(role_reg)) begin
            role_reg <= rwc_pkg::ROLE_REDUNDANT; // [R16]
        end else if (write_take) begin
            role_reg <= cmd_wdata_i; // [R14] [R15]
        end
    end

    // Command answer, one cycle after the request
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            rsp_data_reg <= 8'h00;
            rsp_pec_reg <= 8'h00;
        end else begin
            ack_reg <= ours;
            err_reg <= ours && cmd_write_i && !(pec_ok && val_ok); // [R18]
            if (ours && !cmd_write_i) begin
                rsp_data_reg <= role_reg;
                rsp_pec_reg <= pec_rd; // [R18]
            end
        end
    end

    // Load hysteresis between enable and disable levels
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            load_hi_reg <= 1'b0;
        end else if (above_en_s) begin
            load_hi_reg <= 1'b1; // [R7]
        end else if (below_dis_s) begin
            load_hi_reg <= 1'b0;
        end
    end

    // Converter state; standby needs a high line from an active peer
    always_comb begin
        state_next = rwc_pkg::ST_RUN_FIXED;
        if (!is_sb_role(role_reg)) begin
            state_next = rwc_pkg::ST_RUN_FIXED; // [R13]
        end else if (!wake_s) begin
            state_next = rwc_pkg::ST_WAKE_RUN; // [R2] [R4] [R5]
        end else if (role_reg == rwc_pkg::ROLE_ALWAYS_SB) begin
            state_next = rwc_pkg::ST_STANDBY; // [R15]
        end else if (load_hi_reg) begin
            state_next = rwc_pkg::ST_LOAD_RUN; // [R6]
        end else begin
            state_next = rwc_pkg::ST_STANDBY; // [R6]
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= rwc_pkg::ST_RUN_FIXED;
        end else begin
            state_reg <= state_next; // [R3]
        end
    end

    // Wake line drive: low on trouble, high only in the always-on role
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wake_out_reg <= 1'b0;
            wake_oe_n_reg <= 1'b1;
        end else if (pull_low) begin
            wake_out_reg <= 1'b0; // [R1]
            wake_oe_n_reg <= 1'b0;
        end else if (role_reg == rwc_pkg::ROLE_ALWAYS_ON) begin
            wake_out_reg <= 1'b1; // [R12]
            wake_oe_n_reg <= 1'b0;
        end else begin
            wake_out_reg <= 1'b0; // [R11] [R14]
            wake_oe_n_reg <= 1'b1;
        end
    end

    assign wake_line_o = wake_out_reg;
    assign wake_line_oe_n_o = wake_oe_n_reg;
    assign converter_enable_n_o = (state_reg == rwc_pkg::ST_STANDBY);
    assign role_o = role_reg;
    assign cmd_ack_o = ack_reg;
    assign cmd_err_o = err_reg;
    assign rsp_data_o = rsp_data_reg;
    assign rsp_pec_o = rsp_pec_reg;

    // Helper: cycles spent in standby with the line low
    logic [31:0] wake_wait_cnt;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wake_wait_cnt <= 32'h0000_0000;
        end else if (!wake_s && converter_enable_n_o) begin
            wake_wait_cnt <= wake_wait_cnt + 32'h0000_0001;
        end else begin
            wake_wait_cnt <= 32'h0000_0000;
        end
    end

    sequence s_trouble;
        fault_i || vout_low_s;
    endsequence

    sequence s_line_low_in_standby;
        !wake_s && (state_reg == rwc_pkg::ST_STANDBY);
    endsequence

    sequence s_sb_fall;
        wake_fall && is_sb_role(role_reg);
    endsequence

    a_fault_pull_low: assert property ( // [R1]
        @(posedge clk_i) disable iff (!resetn_i)
        s_trouble |=> (!wake_line_oe_n_o && !wake_line_o))
        else $error("wake line not pulled low on fault");

    a_wake_runs: assert property ( // [R2]
        @(posedge clk_i) disable iff (!resetn_i)
        s_line_low_in_standby |=> !converter_enable_n_o)
        else $error("standby unit not started by wake line");

    a_wake_budget: assert property ( // [R3]
        @(posedge clk_i) disable iff (!resetn_i)
        wake_wait_cnt < WAKE_LIMIT_CYC)
        else $error("converter start exceeded wake budget");

    a_no_high_runs: assert property ( // [R4]
        @(posedge clk_i) disable iff (!resetn_i)
        !wake_s ##1 !wake_s |-> !converter_enable_n_o)
        else $error("unit idle without active peer");

    a_standby_cond: assert property ( // [R6]
        @(posedge clk_i) disable iff (!resetn_i)
        converter_enable_n_o |-> $past(wake_s) && is_sb_role($past(role_reg))
            && (!$past(load_hi_reg) || $past(role_reg) == rwc_pkg::ROLE_ALWAYS_SB))
        else $error("standby outside allowed combination");

    a_fixed_roles_run: assert property ( // [R13]
        @(posedge clk_i) disable iff (!resetn_i)
        (role_reg <= rwc_pkg::ROLE_ALWAYS_ON) |=> !converter_enable_n_o)
        else $error("fixed role converter stopped");

    a_active_drives: assert property ( // [R12]
        @(posedge clk_i) disable iff (!resetn_i)
        (role_reg == rwc_pkg::ROLE_ALWAYS_ON) && !fault_i && !vout_low_s
            |=> wake_line_o && !wake_line_oe_n_o)
        else $error("active unit not driving line high");

    a_passive_float: assert property ( // [R11]
        @(posedge clk_i) disable iff (!resetn_i)
        (role_reg != rwc_pkg::ROLE_ALWAYS_ON) && !fault_i && !vout_low_s
            |=> wake_line_oe_n_o)
        else $error("passive unit driving wake line");

    a_always_sb: assert property ( // [R15]
        @(posedge clk_i) disable iff (!resetn_i)
        (role_reg == rwc_pkg::ROLE_ALWAYS_SB) && wake_s && $stable(role_reg)
            |=> converter_enable_n_o)
        else $error("always-standby unit running with line high");

    a_role_revert: assert property ( // [R16]
        @(posedge clk_i) disable iff (!resetn_i)
        s_sb_fall |=> (role_reg == rwc_pkg::ROLE_REDUNDANT))
        else $error("standby role not reverted on wake");

    a_bad_pec_kept: assert property ( // [R18]
        @(posedge clk_i) disable iff (!resetn_i)
        ours && cmd_write_i && !pec_ok && !wake_fall |=> $stable(role_reg) && cmd_err_o)
        else $error("role changed by bad packet check");

endmodule

`default_nettype wire

//--- tb/rwc_peer.sv
`timescale 1ns/100ps
`default_nettype none

module rwc_peer (
    // Behaviour picked by the bench: 0 healthy idle, 1 always-on, 2 faulted
    input wire logic [1:0] mode_i,
    // Open-drain drive onto the shared wake line
    output logic drv_o,
    output logic oe_n_o
);
    // A healthy idle peer lets go of the line completely
    always_comb begin
        oe_n_o = (mode_i == 2'd0);
        drv_o = (mode_i == 2'd1);
    end
endmodule

`default_nettype wire

//--- tb/tb_redundancy_wake_control.sv
`timescale 1ns/100ps
`default_nettype none

module tb_redundancy_wake_control;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic fault_i = 1'b0;
    logic vout_low_i = 1'b0;
    logic [7:0] load_share_i = 8'h00;
    logic cmd_valid_i = 1'b0;
    logic cmd_write_i = 1'b0;
    logic [6:0] dev_addr_i = 7'h00;
    logic [7:0] cmd_code_i = 8'h00;
    logic [7:0] cmd_wdata_i = 8'h00;
    logic [7:0] cmd_pec_i = 8'h00;
    logic [1:0] peer_mode = 2'd0;
    logic wake_line_o, wake_line_oe_n_o, cmd_ack_o, cmd_err_o, converter_enable_n_o;
    logic peer_drv, peer_oe_n, wake_line;
    logic [7:0] rsp_data_o, rsp_pec_o, role_o, role_m;
    logic [17:0] note;
    logic [17:0] exp_q[$];
    int fails = 0;
    int check_count = 0;
    int seed_ret;
    int en_c [3];
    int dis_c [3];

    always #5 clk_i = ~clk_i;

    // Low from anyone wins; an undriven line is pulled down
    assign wake_line = ((!wake_line_oe_n_o && !wake_line_o) || (!peer_oe_n && !peer_drv)) ? 1'b0 :
        ((!wake_line_oe_n_o && wake_line_o) || (!peer_oe_n && peer_drv));

    rwc_peer peer (.mode_i(peer_mode), .drv_o(peer_drv), .oe_n_o(peer_oe_n));

    rwc_wake_ctrl #(.WAKE_LIMIT_CYC(50)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .wake_line_i(wake_line),
        .wake_line_o(wake_line_o), .wake_line_oe_n_o(wake_line_oe_n_o),
        .fault_i(fault_i), .vout_low_i(vout_low_i), .load_share_i(load_share_i),
        .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .dev_addr_i(dev_addr_i),
        .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i), .cmd_pec_i(cmd_pec_i),
        .cmd_ack_o(cmd_ack_o), .cmd_err_o(cmd_err_o), .rsp_data_o(rsp_data_o),
        .rsp_pec_o(rsp_pec_o), .converter_enable_n_o(converter_enable_n_o), .role_o(role_o)
    );

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
        end
        return r;
    endfunction

    // One request per call; the expected answer is queued for the monitor
    task automatic cmd(input logic wr, input logic [7:0] code, input logic [7:0] d,
        input logic bad);
        logic [7:0] a0;
        logic ok;
        @(negedge clk_i);
        dev_addr_i = 7'($urandom);
        a0 = {dev_addr_i, 1'b0};
        cmd_valid_i = 1'b1;
        cmd_write_i = wr;
        cmd_code_i = code;
        cmd_wdata_i = d;
        cmd_pec_i = crc8(crc8(crc8(8'h00, a0), code), d) ^ {7'h00, bad};
        ok = !bad && d <= 8'h05;
        if (code == 8'hd0 && wr) begin
            exp_q.push_back({1'b0, !ok, 16'h0000});
            if (ok) role_m = d;
        end else if (code == 8'hd0) begin
            exp_q.push_back({1'b1, 1'b0, role_m,
                crc8(crc8(crc8(crc8(8'h00, a0), 8'hd0), a0 | 8'h01), role_m)});
        end
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
    endtask

    task automatic wait_en(input logic v, input int lim);
        int n;
        n = 0;
        while (converter_enable_n_o !== v && n < lim) begin
            @(negedge clk_i);
            n++;
        end
        check("converter_enable_n", {7'h00, converter_enable_n_o}, {7'h00, v});
        // Only a real timeout ends the run early
        if (converter_enable_n_o !== v) begin
            end_sim();
        end
    endtask

    task automatic stay_en(input logic v);
        repeat (8) @(negedge clk_i);
        check("converter_enable_n held", {7'h00, converter_enable_n_o}, {7'h00, v});
    endtask

    // Answers come one cycle after the request edge
    always @(negedge clk_i) begin
        if (resetn_i && cmd_ack_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected ack", 8'h01, 8'h00);
            end else begin
                note = exp_q.pop_front();
                check("cmd_err", {7'h00, cmd_err_o}, {7'h00, note[16]});
                if (note[17]) begin
                    check("rsp_data", rsp_data_o, note[15:8]);
                    check("rsp_pec", rsp_pec_o, note[7:0]);
                end
            end
        end
    end

    initial begin
        #900000;
        fails++;
        end_sim();
    end

    initial begin
        seed_ret = $urandom(32'h9f56);
        role_m = 8'h00;
        en_c = '{rwc_pkg::EN1_MV * 255 / 8000, rwc_pkg::EN2_MV * 255 / 8000,
            rwc_pkg::EN3_MV * 255 / 8000};
        dis_c = '{rwc_pkg::DIS1_MV * 255 / 8000, rwc_pkg::DIS2_MV * 255 / 8000,
            rwc_pkg::DIS3_MV * 255 / 8000};
        repeat (4) @(negedge clk_i);
        check("role_o reset", role_o, 8'h00);
        check("oe_n reset", {7'h00, wake_line_oe_n_o}, 8'h01);
        check("enable_n reset", {7'h00, converter_enable_n_o}, 8'h00);
        resetn_i = 1'b1;
        // Peer holds the line high so role changes cause no wake fall
        peer_mode = 2'd1;
        for (int r = 0; r < 6; r++) begin
            cmd(1'b1, 8'hd0, 8'(r), 1'b0);
            cmd(1'b0, 8'hd0, 8'h00, 1'b0);
        end
        // Out of range, corrupted check byte, foreign code: none may land
        cmd(1'b1, 8'hd0, 8'h06, 1'b0);
        cmd(1'b1, 8'hd0, 8'h02, 1'b1);
        cmd(1'b1, 8'h20, 8'h03, 1'b0);
        cmd(1'b0, 8'hd0, 8'h00, 1'b0);
        peer_mode = 2'd1;
        load_share_i = 8'hff;
        stay_en(1'b1);
        cmd(1'b1, 8'hd0, 8'h01, 1'b0);
        wait_en(1'b0, 8);
        peer_mode = 2'd0;
        check("wake drive high", {wake_line_oe_n_o, wake_line_o}, 8'h01);
        fault_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check("wake pull on fault", {wake_line_oe_n_o, wake_line_o}, 8'h00);
        fault_i = 1'b0;
        vout_low_i = 1'b1;
        repeat (4) @(negedge clk_i);
        check("wake pull on undervoltage", {wake_line_oe_n_o, wake_line_o}, 8'h00);
        check("always-on role kept", role_o, 8'h01);
        vout_low_i = 1'b0;
        peer_mode = 2'd1;
        for (int k = 0; k < 3; k++) begin
            load_share_i = 8'($urandom_range(dis_c[0] - 2, 0));
            cmd(1'b1, 8'hd0, 8'(2 + k), 1'b0);
            wait_en(1'b1, 8);
            load_share_i = 8'(en_c[k] - 2);
            stay_en(1'b1);
            load_share_i = 8'(en_c[k] + 1);
            wait_en(1'b0, 8);
            load_share_i = 8'(dis_c[k] + 2);
            stay_en(1'b0);
            load_share_i = 8'(dis_c[k] - 2);
            wait_en(1'b1, 8);
        end
        // Low load first, or position one sees the last level as high
        load_share_i = 8'($urandom_range(dis_c[0] - 2, 0));
        cmd(1'b1, 8'hd0, 8'h02, 1'b0);
        wait_en(1'b1, 8);
        peer_mode = 2'd2;
        wait_en(1'b0, 5);
        repeat (2) @(negedge clk_i);
        check("role after wake", role_o, 8'h00);
        role_m = 8'h00;
        peer_mode = 2'd1;
        stay_en(1'b0);
        cmd(1'b1, 8'hd0, 8'h02, 1'b0);
        wait_en(1'b1, 8);
        peer_mode = 2'd0;
        wait_en(1'b0, 5);
        cmd(1'b1, 8'hd0, 8'h05, 1'b0);
        stay_en(1'b0);
        check("role with line low", role_o, 8'h05);
        repeat (4) @(negedge clk_i);
        // Every queued answer must have been acknowledged
        check("pending answers", 8'(exp_q.size()), 8'h00);
        end_sim();
    end
endmodule

`default_nettype wire
